/* File: hdl/adcf_pkg.sv */
// Shared constants and types of the converter status flag block
package adcf_pkg;
	localparam int NCH_DEF = 4;
	localparam int DW_DEF  = 10;

	localparam logic [7:0] OFF_CTRL     = 8'h00;
	localparam logic [7:0] OFF_MODE     = 8'h04;
	localparam logic [7:0] OFF_CHEN     = 8'h08;
	localparam logic [7:0] OFF_STAT     = 8'h0c;
	localparam logic [7:0] OFF_LAST     = 8'h10;
	localparam logic [7:0] OFF_IRQ_STAT = 8'h14;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h18;
	localparam logic [2:0] OFF_CHAN_BLK = 3'h1;

	localparam int CTRL_START_BIT = 0;
	localparam int MODE_SLEEP_BIT = 0;
	localparam int STAT_EOC_LSB   = 0;
	localparam int STAT_CHANNEL_OVERRUN_FLAG_LSB  = 8;
	localparam int STAT_DATA_READY_FLAG_BIT  = 16;
	localparam int STAT_GENERAL_OVERRUN_FLAG_BIT = 17;
	localparam int STAT_SLEEP_BIT = 18;
	localparam int LAST_CHAN_LSB  = 16;

	localparam int NEV       = 4;
	localparam int EV_EOC    = 0;
	localparam int EV_DATA_READY_FLAG   = 1;
	localparam int EV_CHANNEL_OVERRUN_FLAG   = 2;
	localparam int EV_GENERAL_OVERRUN_FLAG  = 3;

	localparam logic           MODE_SLEEP_RST = 1'b0;
	localparam logic [NEV-1:0] IRQ_MASK_RST   = 4'h0;

	typedef enum logic [1:0] {
		ADCF_BUS_IDLE = 2'b00,
		ADCF_BUS_BUSY = 2'b01,
		ADCF_BUS_ACK  = 2'b11
	} adcf_bus_t;
endpackage

/* File: hdl/adcf_result_mem.sv */
// Per-channel result storage with registered read port
`timescale 1ns/1ps
`default_nettype none
module adcf_result_mem #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 4,
	parameter int AW    = 2
) (
	input  wire logic             mclk,
	input  wire logic             rst_b,
	input  wire logic             wr_en,
	input  wire logic [AW-1:0]    wr_addr,
	input  wire logic [WIDTH-1:0] wr_data,
	input  wire logic             rd_en,
	input  wire logic [AW-1:0]    rd_addr,
	output logic      [WIDTH-1:0] rd_q
);
	initial begin
		if (DEPTH < 2 || DEPTH > (1 << AW) || WIDTH < 1) begin
			$error("adcf_result_mem: bad geometry");
		end
	end

	logic [WIDTH-1:0] mem_q [DEPTH];

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_q[i] <= '0;
			end
		end else if (wr_en) begin
			mem_q[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rd_q <= '0;
		end else if (rd_en) begin
			rd_q <= mem_q[rd_addr];
		end
	end
endmodule
`default_nettype wire

/* File: hdl/adcf_status.sv */
// Converter status flags, result registers and Wishbone register slave
//
// Summary of operation
// RL1: Data-ready clears only on last-result read, never on channel result reads.
// RL2: Enabled completion stores channel and last result and raises data-ready.
// RL3: Completion on a disabled channel stores nothing and leaves data-ready alone.
// RL4: Channel read with concurrent enabled completion still raises data-ready.
// RL5: Enabled completion while data-ready set raises general overrun, despite same-cycle reads.
// RL6: Status read clears general overrun unless a new overrun arises then.
// RL7: Enabled completion with channel completion flag set raises that channel's overrun.
// RL8: Status read clears channel overruns unless a new channel overrun arises then.
// RL9: Channel result read clears only that channel's completion flag.
// RL10: Disabled channel never raises its completion flag, whatever reads coincide.
// RL11: Sleep takes effect only at the end of a conversion.
// RL12: Software selects sleep then starts, to sleep after that conversion.
// RL13: Same-cycle set and clear both apply; set wins for each flag.
`timescale 1ns/1ps
`default_nettype none
module adcf_status
	import adcf_pkg::*;
#(
	parameter int NCH = NCH_DEF,
	parameter int DW  = DW_DEF
) (
	input  wire logic                mclk,
	input  wire logic                rst_b,
	input  wire logic                wb_cyc_i,
	input  wire logic                wb_stb_i,
	input  wire logic                wb_we_i,
	input  wire logic [7:0]          wb_adr_i,
	input  wire logic [3:0]          wb_sel_i,
	input  wire logic [31:0]         wb_dat_i,
	output logic      [31:0]         wb_dat_o,
	output logic                     wb_ack_o,
	input  wire logic                conv_done,
	input  wire logic [$clog2(NCH)-1:0] conv_chan,
	input  wire logic [DW-1:0]       conv_data,
	output logic                     conv_start,
	output logic      [NCH-1:0]      chan_en,
	output logic                     adc_sleep,
	output logic                     irq
);
	localparam int CW = $clog2(NCH);

	initial begin
		if (NCH < 2 || NCH > 8 || DW < 1 || DW > 16) begin
			$error("adcf_status: NCH must be 2..8 and DW 1..16");
		end
	end

	typedef struct packed {
		adcf_bus_t      st;
		logic           mem_sel;
		logic [31:0]    dat;
		logic [NCH-1:0] chen;
		logic [NCH-1:0] eoc;
		logic [NCH-1:0] channel_overrun_flag;
		logic           data_ready_flag;
		logic           general_overrun_flag;
		logic           sleep_sel;
		logic           asleep;
		logic           start;
		logic [DW-1:0]  last;
		logic [CW-1:0]  last_ch;
		logic [NEV-1:0] ev;
		logic [NEV-1:0] mask;
	} adcf_state_t;

	adcf_state_t    s_q;
	adcf_state_t    s_d;
	logic           acc;
	logic           wr;
	logic           rd_stat;
	logic           rd_last;
	logic           rd_chan;
	logic           done_ok;
	logic [CW-1:0]  idx;
	logic [NCH-1:0] idx_hot;
	logic [NCH-1:0] eoc_set;
	logic [NCH-1:0] eoc_clr;
	logic [NCH-1:0] channel_overrun_flag_set;
	logic           general_overrun_flag_set;
	logic [NEV-1:0] ev_set;
	logic [DW-1:0]  mem_rd;

	adcf_result_mem #(
		.WIDTH (DW),
		.DEPTH (NCH),
		.AW    (CW)
	) u_mem (
		.mclk    (mclk),
		.rst_b   (rst_b),
		.wr_en   (done_ok), // [RL2] [RL3]
		.wr_addr (conv_chan),
		.wr_data (conv_data),
		.rd_en   (rd_chan),
		.rd_addr (idx),
		.rd_q    (mem_rd)
	);

	always_comb begin
		s_d       = s_q;
		s_d.start = 1'b0;
		acc       = (s_q.st == ADCF_BUS_IDLE) && wb_cyc_i && wb_stb_i;
		wr        = acc && wb_we_i && wb_sel_i[0];
		rd_stat   = acc && !wb_we_i && (wb_adr_i == OFF_STAT);
		rd_last   = acc && !wb_we_i && (wb_adr_i == OFF_LAST);
		idx       = wb_adr_i[2 +: CW];
		rd_chan   = acc && !wb_we_i && (wb_adr_i[7:5] == OFF_CHAN_BLK) && (32'(wb_adr_i[4:2]) < NCH)
			&& (wb_adr_i[1:0] == 2'b00);
		done_ok   = conv_done && s_q.chen[conv_chan]; // [RL3] [RL10]
		idx_hot   = '0;
		eoc_set   = '0;
		eoc_clr   = '0;
		for (int i = 0; i < NCH; i++) begin
			idx_hot[i] = (idx == CW'(i));
			eoc_set[i] = done_ok && (conv_chan == CW'(i));
			eoc_clr[i] = (rd_chan && idx_hot[i]) || (rd_last && (s_q.last_ch == CW'(i))); // [RL9]
		end
		channel_overrun_flag_set  = eoc_set & s_q.eoc; // [RL7]
		general_overrun_flag_set = done_ok && s_q.data_ready_flag; // [RL5]
		s_d.eoc   = (s_q.eoc & ~eoc_clr) | eoc_set; // [RL9] [RL10] [RL13]
		s_d.channel_overrun_flag  = (rd_stat ? '0 : s_q.channel_overrun_flag) | channel_overrun_flag_set; // [RL8] [RL13]
		s_d.general_overrun_flag = (s_q.general_overrun_flag && !rd_stat) || general_overrun_flag_set; // [RL6] [RL13]
		s_d.data_ready_flag  = (s_q.data_ready_flag && !rd_last) || done_ok; // [RL1] [RL2] [RL4] [RL13]
		if (done_ok) begin
			s_d.last    = conv_data; // [RL2]
			s_d.last_ch = conv_chan;
		end
		ev_set           = '0;
		ev_set[EV_EOC]   = |eoc_set;
		ev_set[EV_DATA_READY_FLAG]  = done_ok;
		ev_set[EV_CHANNEL_OVERRUN_FLAG]  = |channel_overrun_flag_set;
		ev_set[EV_GENERAL_OVERRUN_FLAG] = general_overrun_flag_set;
		s_d.ev = s_q.ev;
		if (wr && wb_adr_i == OFF_IRQ_STAT) begin
			s_d.ev = s_q.ev & ~wb_dat_i[NEV-1:0];
		end
		s_d.ev = s_d.ev | ev_set;
		if (wr) begin
			unique case (wb_adr_i)
				OFF_CTRL:     s_d.start = wb_dat_i[CTRL_START_BIT];
				OFF_MODE:     s_d.sleep_sel = wb_dat_i[MODE_SLEEP_BIT];
				OFF_CHEN:     s_d.chen = wb_dat_i[NCH-1:0];
				OFF_IRQ_MASK: s_d.mask = wb_dat_i[NEV-1:0];
				default:      s_d.start = 1'b0;
			endcase
		end
		if (!s_q.sleep_sel) begin
			s_d.asleep = 1'b0;
		end else if (conv_done) begin
			s_d.asleep = 1'b1; // [RL11] [RL12]
		end else if (s_q.start) begin
			s_d.asleep = 1'b0;
		end
		unique case (s_q.st)
			ADCF_BUS_IDLE: begin
				if (acc) begin
					s_d.st      = ADCF_BUS_BUSY;
					s_d.mem_sel = rd_chan;
					s_d.dat     = '0;
					if (!wb_we_i) begin
						unique case (wb_adr_i)
							OFF_MODE:     s_d.dat[MODE_SLEEP_BIT] = s_q.sleep_sel;
							OFF_CHEN:     s_d.dat[NCH-1:0] = s_q.chen;
							OFF_STAT: begin
								s_d.dat[STAT_EOC_LSB +: NCH]  = s_q.eoc;
								s_d.dat[STAT_CHANNEL_OVERRUN_FLAG_LSB +: NCH] = s_q.channel_overrun_flag;
								s_d.dat[STAT_DATA_READY_FLAG_BIT]        = s_q.data_ready_flag;
								s_d.dat[STAT_GENERAL_OVERRUN_FLAG_BIT]       = s_q.general_overrun_flag;
								s_d.dat[STAT_SLEEP_BIT]       = s_q.asleep;
							end
							OFF_LAST: begin
								s_d.dat[DW-1:0]               = s_q.last;
								s_d.dat[LAST_CHAN_LSB +: CW]  = s_q.last_ch;
							end
							OFF_IRQ_STAT: s_d.dat[NEV-1:0] = s_q.ev;
							OFF_IRQ_MASK: s_d.dat[NEV-1:0] = s_q.mask;
							default:      s_d.dat = '0;
						endcase
					end
				end
			end
			ADCF_BUS_BUSY: begin
				s_d.st = ADCF_BUS_ACK;
				if (s_q.mem_sel) begin
					s_d.dat = {{(32 - DW){1'b0}}, mem_rd};
				end
			end
			ADCF_BUS_ACK: begin
				s_d.st = ADCF_BUS_IDLE;
			end
			default: begin
				s_d.st = ADCF_BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			s_q           <= '0;
			s_q.st        <= ADCF_BUS_IDLE;
			s_q.sleep_sel <= MODE_SLEEP_RST;
			s_q.mask      <= IRQ_MASK_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign wb_dat_o   = s_q.dat;
	assign wb_ack_o   = (s_q.st == ADCF_BUS_ACK);
	assign conv_start = s_q.start;
	assign chan_en    = s_q.chen;
	assign adc_sleep  = s_q.asleep;
	assign irq        = |(s_q.ev & s_q.mask);

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_b);

	chk_data_ready_flag_chan_read: assert property (s_q.data_ready_flag && rd_chan |=> s_q.data_ready_flag) // [RL1]
		else $error("data-ready lost on channel read");
	chk_data_ready_flag_on_store: assert property (done_ok |=> s_q.data_ready_flag && s_q.last == $past(conv_data)) // [RL2]
		else $error("completion not stored or data-ready not raised");
	chk_disabled_no_store: assert property (conv_done && !s_q.chen[conv_chan] // [RL3]
		|=> s_q.last == $past(s_q.last) && s_q.data_ready_flag == ($past(s_q.data_ready_flag) && !$past(rd_last)))
		else $error("disabled channel changed last result or data-ready");
	chk_data_ready_flag_read_race: assert property (done_ok && rd_chan |=> s_q.data_ready_flag) // [RL4]
		else $error("channel read suppressed data-ready");
	chk_general_overrun_flag_set: assert property (done_ok && s_q.data_ready_flag |=> s_q.general_overrun_flag) // [RL5]
		else $error("general overrun not raised");
	chk_general_overrun_flag_clear: assert property (rd_stat && !(done_ok && s_q.data_ready_flag) |=> !s_q.general_overrun_flag) // [RL6]
		else $error("general overrun not cleared by status read");
	chk_channel_overrun_flag_set: assert property (done_ok && s_q.eoc[conv_chan] |=> s_q.channel_overrun_flag[$past(conv_chan)]) // [RL7]
		else $error("channel overrun not raised");
	chk_channel_overrun_flag_clear: assert property (rd_stat && !(done_ok && s_q.eoc[conv_chan]) |=> s_q.channel_overrun_flag == '0) // [RL8]
		else $error("channel overruns not cleared by status read");
	chk_eoc_only_own: assert property (rd_chan // [RL9]
		|=> (($past(s_q.eoc) & ~s_q.eoc) & ~$past(idx_hot)) == '0)
		else $error("channel read cleared another completion flag");
	chk_eoc_disabled: assert property (conv_done && !s_q.chen[conv_chan] && !s_q.eoc[conv_chan] // [RL10]
		|=> !s_q.eoc[$past(conv_chan)])
		else $error("disabled channel raised its completion flag");
	chk_sleep_waits: assert property (s_q.sleep_sel && !s_q.asleep && !conv_done // [RL11]
		|=> !s_q.asleep ##0 (s_q.sleep_sel || !s_q.asleep))
		else $error("sleep entered without a conversion end");
	chk_set_beats_clear: assert property (done_ok && rd_last |=> s_q.data_ready_flag ##1 wb_ack_o) // [RL13]
		else $error("clear won over set on data-ready");
	chk_data_ready_flag_last_clear: assert property (rd_last && !done_ok // [RL1]
		|=> !s_q.data_ready_flag)
		else $error("data-ready not cleared by last result read");
	chk_data_ready_flag_hold: assert property (s_q.data_ready_flag && !rd_last // [RL1]
		|=> s_q.data_ready_flag)
		else $error("data-ready cleared without last result read");
	chk_chan_store: assert property (done_ok // [RL2]
		|=> s_q.last_ch == $past(conv_chan))
		else $error("last result channel not stored");
	chk_last_hold: assert property (!done_ok // [RL3]
		|=> s_q.last == $past(s_q.last))
		else $error("last result changed without enabled completion");
	chk_general_overrun_flag_stat_race: assert property (done_ok && s_q.data_ready_flag && rd_stat // [RL5]
		|=> s_q.general_overrun_flag)
		else $error("status read suppressed general overrun");
	chk_general_overrun_flag_hold: assert property (s_q.general_overrun_flag && !rd_stat // [RL6]
		|=> s_q.general_overrun_flag)
		else $error("general overrun lost without status read");
	chk_channel_overrun_flag_stat_race: assert property (rd_stat && done_ok && s_q.eoc[conv_chan] // [RL7]
		|=> s_q.channel_overrun_flag[$past(conv_chan)])
		else $error("status read suppressed channel overrun");
	chk_channel_overrun_flag_chen_race: assert property (wr && wb_adr_i == OFF_CHEN && done_ok && s_q.eoc[conv_chan] // [RL7]
		|=> s_q.channel_overrun_flag[$past(conv_chan)])
		else $error("enable write suppressed channel overrun");
	chk_channel_overrun_flag_hold: assert property (!rd_stat // [RL8]
		|=> (s_q.channel_overrun_flag & $past(s_q.channel_overrun_flag)) == $past(s_q.channel_overrun_flag))
		else $error("channel overrun lost without status read");
	chk_eoc_read_own: assert property (rd_chan && !(done_ok && conv_chan == idx) // [RL9]
		|=> !s_q.eoc[$past(idx)])
		else $error("channel read left its completion flag set");
	chk_disabled_eoc_keep: assert property (conv_done && !s_q.chen[conv_chan] // [RL10]
		|=> s_q.eoc == ($past(s_q.eoc) & ~$past(eoc_clr)))
		else $error("disabled completion changed completion flags");
	chk_sleep_enter: assert property (s_q.sleep_sel && conv_done // [RL11]
		|=> s_q.asleep)
		else $error("sleep not entered at conversion end");
	chk_sleep_leave: assert property (!s_q.sleep_sel // [RL11]
		|=> !s_q.asleep)
		else $error("asleep while sleep not selected");
	chk_eoc_set_wins: assert property (done_ok // [RL13]
		|=> s_q.eoc[$past(conv_chan)])
		else $error("completion flag not raised");
	chk_ack_timing: assert property (acc
		|=> !wb_ack_o ##1 wb_ack_o)
		else $error("acknowledge not two cycles after request");
	chk_ack_pulse: assert property (wb_ack_o
		|=> !wb_ack_o)
		else $error("acknowledge longer than one cycle");
	chk_start_pulse: assert property (conv_start
		|=> !conv_start)
		else $error("start longer than one cycle");
	chk_irq_sticky: assert property (!(wr && wb_adr_i == OFF_IRQ_STAT)
		|=> (s_q.ev & $past(s_q.ev)) == $past(s_q.ev))
		else $error("interrupt status lost without clear");

	cov_read_race: cover property (done_ok && rd_last);
	cov_general_overrun_flag: cover property (general_overrun_flag_set ##2 wb_ack_o);
	cov_sleep: cover property (s_q.sleep_sel && conv_done ##1 s_q.asleep);
	cov_chan_race: cover property (done_ok && rd_chan && conv_chan != idx);
	cov_disabled_done: cover property (conv_done && !s_q.chen[conv_chan]);
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
// Random self-checking testbench of the converter status flag block
`timescale 1ns/1ps
`default_nettype none
module tb_top import adcf_pkg::*; ;
	logic        mclk, rst_b, cyc, stb, we, conv_done, m_slp, m_rdy, m_gov;
	logic [7:0]  adr;
	logic [31:0] wdat, m_last;
	logic [1:0]  cch;
	logic [9:0]  cdat;
	logic [3:0]  m_eoc, m_ovr, m_en, m_irq, m_msk;
	logic [9:0]  m_res [4];
	logic [31:0] rdat;
	logic        ack, cst, slp, irq;
	logic [3:0]  en;
	int          fails, checks, starts;

	localparam logic [7:0] OFFS [8] = '{OFF_STAT, OFF_LAST, OFF_CHEN, OFF_MODE, OFF_IRQ_STAT,
		OFF_IRQ_MASK, 8'h20, 8'h1c};

	adcf_status i_dut (.mclk(mclk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.conv_done(conv_done), .conv_chan(cch), .conv_data(cdat), .conv_start(cst),
		.chan_en(en), .adc_sleep(slp), .irq(irq));

	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	always @(posedge mclk) if (cst === 1'b1) starts++;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk1(input logic got, input logic exp);
		chk({31'h0, got}, {31'h0, exp});
	endtask

	function automatic logic [31:0] exp_rd(input logic [7:0] a);
		if (a[7:5] == OFF_CHAN_BLK) return {22'h0, m_res[a[3:2]]};
		case (a)
			OFF_STAT: return {13'h0, m_slp, m_gov, m_rdy, 4'h0, m_ovr, 4'h0, m_eoc};
			OFF_LAST: return m_last;
			OFF_IRQ_STAT: return {28'h0, m_irq};
			OFF_IRQ_MASK: return {28'h0, m_msk};
			OFF_CHEN: return {28'h0, m_en};
			default: return 32'h0;
		endcase
	endfunction

	// Optional bus access plus optional completion at the taking edge
	task automatic acc(input logic rq, input logic w, input logic [7:0] a, input logic [31:0] d,
			input logic ev, input logic [1:0] c, input logic [9:0] v);
		logic [31:0] e;
		logic [3:0]  oe;
		logic        orr;
		int          n;
		e = exp_rd(a);
		oe = m_eoc;
		orr = m_rdy;
		@(posedge mclk);
		cyc <= rq;
		stb <= rq;
		we <= w;
		adr <= a;
		wdat <= d;
		conv_done <= ev;
		cch <= c;
		cdat <= v;
		@(posedge mclk);
		conv_done <= 1'b0;
		n = 0;
		while (rq && ack !== 1'b1 && n < 20) begin
			@(posedge mclk);
			n++;
		end
		if (n == 20) begin
			fails++;
			$display("[FAIL] %0t no acknowledge", $time);
		end
		cyc <= 1'b0;
		stb <= 1'b0;
		if (rq && !w) chk(rdat, e);
		if (rq && !w && a == OFF_STAT) {m_ovr, m_gov} = '0;
		if (rq && !w && a == OFF_LAST) begin
			m_rdy = 1'b0;
			m_eoc[m_last[17:16]] = 1'b0;
		end
		if (rq && !w && a[7:5] == OFF_CHAN_BLK) m_eoc[a[3:2]] = 1'b0;
		if (rq && w && a == OFF_CHEN) m_en = d[3:0];
		if (rq && w && a == OFF_IRQ_MASK) m_msk = d[3:0];
		if (rq && w && a == OFF_IRQ_STAT) m_irq = m_irq & ~d[3:0];
		if (ev && m_en[c]) begin
			m_ovr[c] = m_ovr[c] | oe[c];
			m_gov = m_gov | orr;
			m_irq = m_irq | {orr, oe[c], 2'b11};
			m_eoc[c] = 1'b1;
			m_rdy = 1'b1;
			m_res[c] = v;
			m_last = {14'h0, c, 6'h0, v};
		end
		@(posedge mclk);
		chk1(irq, |(m_irq & m_msk));
		chk(32'(en), 32'(m_en));
	endtask

	task automatic report_and_stop;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial begin
		#100000;
		fails++;
		$display("[FAIL] %0t watchdog expired", $time);
		report_and_stop();
	end

	initial begin
		int          k, s;
		logic [31:0] d;
		logic [9:0]  v;
		logic [1:0]  c;
		logic        ev;
		{cyc, stb, we, conv_done, rst_b, m_slp, m_rdy, m_gov} = '0;
		{adr, wdat, cch, cdat, m_last, m_eoc, m_ovr, m_en, m_irq, m_msk} = '0;
		m_res = '{default: '0};
		s = $urandom(75);
		repeat (3) @(posedge mclk);
		rst_b <= 1'b1;
		foreach (OFFS[i]) acc(1, 0, OFFS[i], 0, 0, 0, 0);
		chk1(slp, 1'b0);
		acc(1, 1, 8'h1c, '1, 0, 0, 0);
		acc(1, 1, OFF_STAT, '1, 0, 0, 0);
		acc(1, 1, OFF_CHEN, 32'hf, 0, 0, 0);
		acc(0, 0, 0, 0, 1, 0, 10'h3a5);
		acc(1, 0, 8'h24, 0, 1, 0, 10'h0c3);
		acc(1, 0, 8'h20, 0, 0, 0, 0);
		acc(1, 0, OFF_LAST, 0, 0, 0, 0);
		acc(1, 0, OFF_STAT, 0, 1, 0, 10'h111);
		acc(1, 0, OFF_STAT, 0, 0, 0, 0);
		repeat (250) begin
			k = $urandom % 5;
			c = 2'($urandom);
			v = 10'($urandom);
			ev = 1'($urandom);
			d = $urandom;
			d[c] = m_en[c];
			case (k)
				0: acc(1, 0, OFF_STAT, 0, ev, c, v);
				1: acc(1, 0, {OFF_CHAN_BLK, 1'b0, d[5:4], 2'h0}, 0, ev, c, v);
				2: acc(1, 0, OFF_LAST, 0, ev, c, v);
				3: acc(1, 1, OFF_CHEN, d, ev, c, v);
				default: acc(0, 0, 0, 0, 1'b1, c, v);
			endcase
		end
		acc(1, 1, OFF_CHEN, 32'hf, 0, 0, 0);
		acc(1, 1, OFF_MODE, 32'h1, 0, 0, 0);
		repeat (5) @(posedge mclk);
		chk1(slp, 1'b0);
		starts = 0;
		acc(1, 1, OFF_CTRL, 32'h1, 0, 0, 0);
		chk(32'(starts), 32'h1);
		acc(0, 0, 0, 0, 1, 2, 10'h155);
		m_slp = 1'b1;
		chk1(slp, 1'b1);
		acc(1, 0, OFF_STAT, 0, 0, 0, 0);
		acc(1, 1, OFF_MODE, 0, 0, 0, 0);
		m_slp = 1'b0;
		chk1(slp, 1'b0);
		for (int i = 0; i < 4; i++) acc(1, 0, {OFF_CHAN_BLK, 1'b0, 2'(i), 2'h0}, 0, 0, 0, 0);
		acc(1, 0, OFF_LAST, 0, 0, 0, 0);
		acc(1, 0, OFF_STAT, 0, 0, 0, 0);
		acc(1, 1, OFF_IRQ_STAT, 32'hf, 0, 0, 0);
		acc(1, 0, OFF_IRQ_STAT, 0, 0, 0, 0);
		acc(1, 1, OFF_IRQ_MASK, 32'h2, 0, 0, 0);
		acc(0, 0, 0, 0, 1, 1, 10'h02a);
		acc(1, 0, OFF_IRQ_STAT, 0, 0, 0, 0);
		acc(1, 1, OFF_IRQ_MASK, 0, 0, 0, 0);
		acc(1, 1, OFF_IRQ_MASK, 32'h2, 0, 0, 0);
		acc(1, 1, OFF_IRQ_STAT, 32'h2, 0, 0, 0);
		acc(1, 0, OFF_IRQ_STAT, 0, 0, 0, 0);
		report_and_stop();
	end
endmodule
`default_nettype wire
